// ==== src/comm_sup_pkg.sv ====
package comm_sup_pkg;

  // Register map, word offsets on the plain register port
  localparam logic [3:0] ADDR_WAIT = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [3:0] ADDR_POLICY = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_HIST = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h5;

  // Status field positions
  localparam int ST_ALARM = 0;
  localparam int ST_LINE_IND = 1;
  localparam int ST_OPT_IND = 2;
  localparam int ST_RECOG = 3;
  localparam int ST_MINOR = 4;
  localparam int ST_RESTART = 5;
  localparam int ST_STATE_LO = 8;

  // Reset values
  localparam logic [13:0] WAIT_RST = 14'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [1:0] POLICY_RST = 2'h0;

  // Setting limits
  localparam logic [13:0] WAIT_MAX = 14'h270E; // 9998 steps = 999.8 s

  // Alarm data codes
  localparam logic [7:0] CODE_LINE = 8'hA1;
  localparam logic [7:0] CODE_OPT = 8'hF1;
  localparam logic [7:0] CODE_NONE = 8'h00;

  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int WAIT_STEP_MS = 100;
  localparam int STEP_CYCLES = CLK_HZ / 1000 * WAIT_STEP_MS;
  localparam int SAVE_PERIOD_S = 3600;
  localparam longint SAVE_CYCLES = longint'(CLK_HZ) * SAVE_PERIOD_S;

  typedef enum logic [2:0] {
    S_RUN,
    S_WAIT,
    S_COAST,
    S_DECEL,
    S_STOPPED,
    S_CONT
  } sup_state_t;

  // Drive command bundle
  typedef struct packed {
    logic run;
    logic [15:0] speed;
  } drive_cmd_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ==== src/comm_error_supervisor.sv ====
// How it works
// - Supervision acts only while network operation mode is selected.
// - Line fault becomes an error only after persisting the programmed wait.
// - Recovery before the wait expires leaves operation and indication normal.
// - Error count rises by one at every line fault onset.
// - Writing zero clears the count; other written values are ignored.
// - Count copied to nonvolatile store hourly; reset restores saved value.
// - Stop policy accepts 0 to 3 only and resets to 0.
// - Line error action: coast+alarm, decel+alarm, decel, or continue.
// - Option fault: coast for policies 0,3; decelerate then alarm for 1,2.
// - On fault clear: 0,1 stay stopped; 2 restarts; 3 continues.
// - Policy 2 restart reuses the run and speed command before the fault.
// - Policy 2 line recovery during deceleration restarts acceleration at once.
// - Fault deceleration and restart use ordinary ramp times.
// - Line fault reports code A1 hex, option fault code F1 hex.
// - Alarm drives the fault output pin and a status alarm bit.
// - Alarmed faults enter history; others only overlay the latest entry.
// - After a non-alarmed fault clears, indication and history restore.
// - Line fault in network mode also stops data communication.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module comm_error_supervisor #(
  parameter int STEP_CYC = comm_sup_pkg::STEP_CYCLES,
  parameter longint SAVE_CYC = comm_sup_pkg::SAVE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire comm_sup_pkg::reg_req_t req,
  output logic [15:0] rdata,
  input wire logic net_mode,
  input wire logic line_fault_pin,
  input wire logic opt_fault_pin,
  input wire comm_sup_pkg::drive_cmd_t cmd_in,
  input wire logic stopped,
  input wire logic [15:0] nv_count,
  output comm_sup_pkg::drive_cmd_t cmd_out,
  output logic coast_req,
  output logic decel_req,
  output logic restart_req,
  output logic comm_stop,
  output logic fault_output_signal,
  output logic line_fault_indication,
  output logic opt_fault_indication,
  output logic [7:0] alarm_code,
  output logic [7:0] history_disp,
  output logic nv_save,
  output logic [15:0] nv_save_data
);

  // Counter widths below fix the largest timing counts that can be served
  if (STEP_CYC < 1 || SAVE_CYC < 1) begin : g_bad_timing
    $error("Timing counts must be at least one cycle");
  end
  if (SAVE_CYC > 64'h0000_03FF_FFFF_FFFF) begin : g_save_too_long
    $error("Save period exceeds the 42-bit save counter");
  end

  typedef struct packed {
    logic [1:0] line_sy;
    logic [1:0] opt_sy;
    logic [1:0] mode_sy;
    comm_sup_pkg::drive_cmd_t cmd_d1;
    comm_sup_pkg::drive_cmd_t cmd_d2;
    logic line_prev;
    logic loaded;
    logic [13:0] wait_ff;
    logic [15:0] count;
    logic [1:0] policy;
    comm_sup_pkg::sup_state_t st;
    logic [31:0] step_cnt;
    logic [13:0] steps;
    logic [41:0] save_cnt;
    logic opt_err;
    comm_sup_pkg::drive_cmd_t held;
    comm_sup_pkg::drive_cmd_t cmd;
    logic coast;
    logic decel;
    logic restart;
    logic cstop;
    logic alarm;
    logic line_ind;
    logic opt_ind;
    logic [7:0] code;
    logic [7:0] hist;
    logic [7:0] hist_saved;
    logic save;
    logic [15:0] rdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  logic line_f;
  logic opt_f;
  logic expired;

  // Policy-2 line faults are the only ones that may restart the drive
  function automatic logic may_restart(logic [7:0] code, logic [1:0] pol);
    return code == comm_sup_pkg::CODE_LINE && pol == 2'h2;
  endfunction

  // Mode is a pin level too, so it rides the same two-flop delay
  assign line_f = cur_ff.line_sy[1] & cur_ff.mode_sy[1];
  assign opt_f = cur_ff.opt_sy[1] & cur_ff.mode_sy[1];
  // Zero wait expires immediately, no counting needed
  assign expired = (cur_ff.wait_ff == 14'h0000) ||
                   (cur_ff.steps >= cur_ff.wait_ff);

  // Whole supervisor: sync, registers, fault sequencing
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.line_sy = {cur_ff.line_sy[0], line_fault_pin};
    nxt_cur.opt_sy = {cur_ff.opt_sy[0], opt_fault_pin};
    nxt_cur.mode_sy = {cur_ff.mode_sy[0], net_mode};
    // Command delayed as long as the fault synchroniser, so a bad frame
    // arriving with the cut never reaches the held copy
    nxt_cur.cmd_d1 = cmd_in;
    nxt_cur.cmd_d2 = cur_ff.cmd_d1;
    nxt_cur.line_prev = line_f;
    nxt_cur.save = 1'b0;
    nxt_cur.restart = 1'b0;

    // Restore the saved count once, right after reset release
    if (!cur_ff.loaded) begin
      nxt_cur.loaded = 1'b1;
      nxt_cur.count = nv_count;
    end

    // Onset counting happens even if the wait later forgives it
    if (line_f && !cur_ff.line_prev) begin
      nxt_cur.count = cur_ff.count + 16'h0001;
    end

    // Hourly copy to the nonvolatile store
    // Only the count is saved; a reset between copies loses recent onsets
    if (cur_ff.save_cnt >= 42'(SAVE_CYC - 1)) begin
      nxt_cur.save_cnt = '0;
      nxt_cur.save = 1'b1;
    end else begin
      nxt_cur.save_cnt = cur_ff.save_cnt + 42'h1;
    end

    // Register writes; clear wins over a same-cycle onset only by zero write
    if (req.wr) begin
      case (req.addr)
        comm_sup_pkg::ADDR_WAIT: begin
          if (req.wdata[13:0] <= comm_sup_pkg::WAIT_MAX &&
              req.wdata[15:14] == 2'h0) begin
            nxt_cur.wait_ff = req.wdata[13:0];
          end
        end
        comm_sup_pkg::ADDR_COUNT: begin
          if (req.wdata == 16'h0000) begin
            nxt_cur.count = 16'h0000;
          end
        end
        comm_sup_pkg::ADDR_POLICY: begin
          if (req.wdata[15:2] == 14'h0000) begin
            nxt_cur.policy = req.wdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Read mux, data valid the cycle after the strobe
    nxt_cur.rdata = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        comm_sup_pkg::ADDR_WAIT: nxt_cur.rdata = {2'h0, cur_ff.wait_ff};
        comm_sup_pkg::ADDR_COUNT: nxt_cur.rdata = cur_ff.count;
        comm_sup_pkg::ADDR_POLICY: nxt_cur.rdata = {14'h0, cur_ff.policy};
        comm_sup_pkg::ADDR_STATUS: begin
          nxt_cur.rdata[comm_sup_pkg::ST_ALARM] = cur_ff.alarm;
          nxt_cur.rdata[comm_sup_pkg::ST_LINE_IND] = cur_ff.line_ind;
          nxt_cur.rdata[comm_sup_pkg::ST_OPT_IND] = cur_ff.opt_ind;
          nxt_cur.rdata[comm_sup_pkg::ST_RECOG] = cur_ff.st != 
              comm_sup_pkg::S_RUN && cur_ff.st != comm_sup_pkg::S_WAIT;
          nxt_cur.rdata[comm_sup_pkg::ST_MINOR] =
              cur_ff.st == comm_sup_pkg::S_CONT;
          nxt_cur.rdata[comm_sup_pkg::ST_STATE_LO +: 3] = cur_ff.st;
        end
        comm_sup_pkg::ADDR_HIST: nxt_cur.rdata = {cur_ff.hist_saved,
                                                  cur_ff.hist};
        default: nxt_cur.rdata = 16'h0000;
      endcase
    end

    // Option fault latches; only reset removes it
    if (opt_f) begin
      nxt_cur.opt_err = 1'b1;
    end

    // Step timer runs only while waiting
    // Starting from zero on every entry keeps a glitch from shortening it
    if (cur_ff.st == comm_sup_pkg::S_WAIT) begin
      if (cur_ff.step_cnt >= 32'(STEP_CYC - 1)) begin
        nxt_cur.step_cnt = '0;
        nxt_cur.steps = cur_ff.steps + 14'h1;
      end else begin
        nxt_cur.step_cnt = cur_ff.step_cnt + 32'h1;
      end
    end else begin
      nxt_cur.step_cnt = '0;
      nxt_cur.steps = '0;
    end

    // Track the live command in run, wait and continue; restart replays the held copy
    if (cur_ff.st == comm_sup_pkg::S_RUN || cur_ff.st == comm_sup_pkg::S_WAIT ||
        cur_ff.st == comm_sup_pkg::S_CONT) begin
      nxt_cur.cmd = cmd_in;
    end
    // Held copy freezes once the line is seen bad; the cost is a restart
    // that replays a command up to two cycles old
    if (cur_ff.st == comm_sup_pkg::S_RUN && !line_f) begin
      nxt_cur.held = cur_ff.cmd_d2;
    end

    nxt_cur.cstop = line_f;

    // Fault sequencing
    case (cur_ff.st)
      comm_sup_pkg::S_RUN, comm_sup_pkg::S_WAIT: begin
        if (opt_f || cur_ff.opt_err) begin
          nxt_cur.code = comm_sup_pkg::CODE_OPT;
          if (cur_ff.policy == 2'h0 || cur_ff.policy == 2'h3) begin
            nxt_cur.st = comm_sup_pkg::S_COAST;
          end else begin
            nxt_cur.st = comm_sup_pkg::S_DECEL;
          end
        end else if (line_f && expired) begin
          nxt_cur.code = comm_sup_pkg::CODE_LINE;
          case (cur_ff.policy)
            2'h0: nxt_cur.st = comm_sup_pkg::S_COAST;
            2'h1, 2'h2: nxt_cur.st = comm_sup_pkg::S_DECEL;
            default: nxt_cur.st = comm_sup_pkg::S_CONT;
          endcase
          // Unalarmed line faults only overlay the history
          if (cur_ff.policy[1]) begin
            nxt_cur.hist = comm_sup_pkg::CODE_LINE;
          end
        end else if (line_f) begin
          nxt_cur.st = comm_sup_pkg::S_WAIT;
        end else begin
          nxt_cur.st = comm_sup_pkg::S_RUN;
        end
      end
      comm_sup_pkg::S_DECEL: begin
        // Ordinary ramp time is applied by the drive itself
        nxt_cur.decel = 1'b1;
        if (may_restart(cur_ff.code, cur_ff.policy) && !line_f &&
            !cur_ff.opt_err) begin
          nxt_cur.decel = 1'b0;
          nxt_cur.restart = 1'b1;
          nxt_cur.cmd = cur_ff.held;
          nxt_cur.hist = cur_ff.hist_saved;
          nxt_cur.code = comm_sup_pkg::CODE_NONE;
          nxt_cur.st = comm_sup_pkg::S_RUN;
        end else if (stopped) begin
          nxt_cur.st = comm_sup_pkg::S_STOPPED;
        end
      end
      comm_sup_pkg::S_COAST: begin
        nxt_cur.coast = 1'b1;
        nxt_cur.st = comm_sup_pkg::S_STOPPED;
      end
      comm_sup_pkg::S_STOPPED: begin
        nxt_cur.cmd.run = 1'b0;
        // An option fault arriving during a line stop takes over the cause only while no alarm is latched
        if (cur_ff.opt_err && !cur_ff.alarm) begin
          nxt_cur.code = comm_sup_pkg::CODE_OPT;
        end
        if (may_restart(cur_ff.code, cur_ff.policy) && !line_f &&
            !cur_ff.opt_err) begin
          nxt_cur.decel = 1'b0;
          nxt_cur.restart = 1'b1;
          nxt_cur.cmd = cur_ff.held;
          nxt_cur.hist = cur_ff.hist_saved;
          nxt_cur.code = comm_sup_pkg::CODE_NONE;
          nxt_cur.st = comm_sup_pkg::S_RUN;
        end
      end
      comm_sup_pkg::S_CONT: begin
        if (opt_f) begin
          nxt_cur.st = comm_sup_pkg::S_COAST;
          nxt_cur.code = comm_sup_pkg::CODE_OPT;
        end else if (!line_f) begin
          nxt_cur.hist = cur_ff.hist_saved;
          nxt_cur.code = comm_sup_pkg::CODE_NONE;
          nxt_cur.st = comm_sup_pkg::S_RUN;
        end
      end
      default: nxt_cur.st = comm_sup_pkg::S_RUN;
    endcase

    // Alarm: coast at once, decel policy after the stop
    if (!cur_ff.alarm) begin
      if ((cur_ff.st == comm_sup_pkg::S_COAST) ||
          (cur_ff.st == comm_sup_pkg::S_STOPPED &&
           !may_restart(cur_ff.code, cur_ff.policy))) begin
        nxt_cur.alarm = 1'b1;
        nxt_cur.line_ind = cur_ff.code == comm_sup_pkg::CODE_LINE;
        nxt_cur.opt_ind = cur_ff.code == comm_sup_pkg::CODE_OPT;
        nxt_cur.hist = cur_ff.code;
        nxt_cur.hist_saved = cur_ff.code;
      end
    end
    if (nxt_cur.st != comm_sup_pkg::S_DECEL) begin
      nxt_cur.decel = 1'b0;
    end
  end

  // State register, constants only under reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '0;
      cur_ff.wait_ff <= comm_sup_pkg::WAIT_RST;
      cur_ff.count <= comm_sup_pkg::COUNT_RST;
      cur_ff.policy <= comm_sup_pkg::POLICY_RST;
      cur_ff.st <= comm_sup_pkg::S_RUN;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign rdata = cur_ff.rdata;
  assign cmd_out = cur_ff.cmd;
  assign coast_req = cur_ff.coast;
  assign decel_req = cur_ff.decel;
  assign restart_req = cur_ff.restart;
  assign comm_stop = cur_ff.cstop;
  assign fault_output_signal = cur_ff.alarm;
  assign line_fault_indication = cur_ff.line_ind;
  assign opt_fault_indication = cur_ff.opt_ind;
  assign alarm_code = cur_ff.code;
  assign history_disp = cur_ff.hist;
  assign nv_save = cur_ff.save;
  assign nv_save_data = cur_ff.count;

endmodule // comm_error_supervisor

`default_nettype wire

// ==== tb/comm_error_supervisor_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module comm_sup_checker #(
  parameter longint SAVE_CYC = 50
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire comm_sup_pkg::reg_req_t req,
  input wire logic [15:0] rdata,
  input wire logic net_mode,
  input wire logic coast_req,
  input wire logic restart_req,
  input wire logic comm_stop,
  input wire logic fault_output_signal,
  input wire logic line_fault_indication,
  input wire logic opt_fault_indication,
  input wire logic [7:0] alarm_code,
  input wire logic nv_save
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Bus, mode gating and latching relations
  property p_rd; !$past(req.rd) |-> rdata == 16'h0000; endproperty
  a_rd: assert property (p_rd) else $error("rdata not idle");
  property p_net; !net_mode [*4] |-> !comm_stop; endproperty
  a_net: assert property (p_net) else $error("stop offline");
  property p_hold; fault_output_signal |=> fault_output_signal; endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped");
  property p_coast; $rose(coast_req) |=> fault_output_signal; endproperty
  a_coast: assert property (p_coast) else $error("coast no alarm");
  property p_lcode;
    $rose(line_fault_indication) |-> ##[0:1] alarm_code == 8'hA1;
  endproperty
  a_lcode: assert property (p_lcode) else $error("line code");
  property p_ocode;
    $rose(opt_fault_indication) |-> ##[0:1] alarm_code == 8'hF1;
  endproperty
  a_ocode: assert property (p_ocode) else $error("option code");
  property p_cause;
    $rose(fault_output_signal) |->
      ##[0:1] (line_fault_indication || opt_fault_indication);
  endproperty
  a_cause: assert property (p_cause) else $error("alarm no cause");
  property p_rst; restart_req |=> !restart_req; endproperty
  a_rst: assert property (p_rst) else $error("restart long");
  property p_save; nv_save |=> !nv_save [*8]; endproperty
  a_save: assert property (p_save) else $error("save too often");
  // Main scenarios reached
  cover property ($rose(coast_req));
  cover property ($rose(restart_req));
  cover property ($rose(opt_fault_indication));
endmodule // comm_sup_checker
`default_nettype wire

// ==== tb/net_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module net_master_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic line_cut,
  input wire comm_sup_pkg::drive_cmd_t cmd_set,
  input wire logic coast_req,
  input wire logic decel_req,
  input wire logic restart_req,
  output logic line_fault_pin,
  output comm_sup_pkg::drive_cmd_t cmd_in,
  output logic stopped
);
  logic [3:0] ramp_ff;
  // A cut line delivers garbage, never the last good command
  assign line_fault_pin = line_cut;
  assign cmd_in = line_cut ? ~cmd_set : cmd_set;
  assign stopped = ramp_ff == 4'h8;
  // Drive ramps down while asked to; a restart spins it up again
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) ramp_ff <= 4'h0;
    else if (restart_req) ramp_ff <= 4'h0;
    else if ((coast_req || decel_req) && !stopped) ramp_ff <= ramp_ff + 4'h1;
  end
endmodule // net_master_model
`default_nettype wire

// ==== tb/comm_error_supervisor_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module comm_error_supervisor_test;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic net_mode = 1'b0;
  logic line_cut = 1'b0;
  logic opt_fault_pin = 1'b0;
  comm_sup_pkg::reg_req_t req = '0;
  logic [15:0] rdata, nv_save_data, v, rs_speed;
  logic [15:0] nv_count = 16'h0007;
  logic line_fault_pin, stopped, coast_req, decel_req, restart_req, seen;
  logic comm_stop, fault_output_signal, line_fault_indication;
  logic opt_fault_indication, nv_save;
  logic [7:0] alarm_code, history_disp;
  comm_sup_pkg::drive_cmd_t cmd_set = '{1'b1, 16'h1234};
  comm_sup_pkg::drive_cmd_t cmd_in, cmd_out;
  int mismatches = 0;
  int n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  comm_error_supervisor #(.STEP_CYC(4), .SAVE_CYC(50))
    comm_error_supervisor_inst (.ref_clk, .nrst, .req, .rdata, .net_mode,
    .line_fault_pin, .opt_fault_pin, .cmd_in, .stopped, .nv_count, .cmd_out,
    .coast_req, .decel_req, .restart_req, .comm_stop, .fault_output_signal,
    .line_fault_indication, .opt_fault_indication, .alarm_code,
    .history_disp, .nv_save, .nv_save_data);
  net_master_model net_master_model_inst (.ref_clk, .nrst, .line_cut,
    .cmd_set, .coast_req, .decel_req, .restart_req, .line_fault_pin,
    .cmd_in, .stopped);
  task automatic chk(string w, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", w, e, g);
    end
  endtask
  task automatic bchk(string w, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %b got %b", w, e, g);
    end
  endtask
  // Bus master: one strobe cycle, changed just after the edge
  // An idle edge follows so back-to-back calls never drive req twice at once
  task automatic wr(logic [3:0] a, logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    req <= '0;
    @(posedge ref_clk);
  endtask
  // Read data is taken mid-cycle, where it stands settled
  task automatic rchk(string w, logic [3:0] a, logic [15:0] e);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge ref_clk);
    req <= '0;
    @(negedge ref_clk);
    v = rdata;
    chk(w, e, v);
    @(posedge ref_clk);
  endtask
  // Fresh start under a given policy with a wait of 8 cycles
  task automatic setup(int p, logic net);
    nrst <= 1'b0;
    line_cut <= 1'b0;
    opt_fault_pin <= 1'b0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    net_mode <= net;
    repeat (2) @(posedge ref_clk);
    wr(comm_sup_pkg::ADDR_POLICY, 16'(p));
    wr(comm_sup_pkg::ADDR_WAIT, 16'h0002);
  endtask
  task automatic run(int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge ref_clk);
      if (restart_req === 1'b1) begin
        seen = 1'b1;
        rs_speed = cmd_out.speed;
      end
      @(posedge ref_clk);
    end
  endtask
  function automatic logic alarm_for(int p);
    return p < 2;
  endfunction
  // Status word after a recognised line fault under policy p
  function automatic logic [15:0] status_exp(int p);
    logic [15:0] s;
    logic [2:0] st;
    s = 16'h0000;
    st = (p == 3) ? comm_sup_pkg::S_CONT : comm_sup_pkg::S_STOPPED;
    s[comm_sup_pkg::ST_ALARM] = alarm_for(p);
    s[comm_sup_pkg::ST_LINE_IND] = alarm_for(p);
    s[comm_sup_pkg::ST_RECOG] = 1'b1;
    s[comm_sup_pkg::ST_MINOR] = (p == 3);
    s[comm_sup_pkg::ST_STATE_LO +: 3] = st;
    return s;
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(93));
    cmd_set.speed = 16'($urandom);
    setup(0, 1'b0);
    rchk("count", comm_sup_pkg::ADDR_COUNT, 16'h0007);
    wr(comm_sup_pkg::ADDR_WAIT, 16'h270F);
    wr(comm_sup_pkg::ADDR_POLICY, 16'h0004);
    wr(comm_sup_pkg::ADDR_COUNT, 16'h0003);
    rchk("wait", comm_sup_pkg::ADDR_WAIT, 16'h0002);
    rchk("policy", comm_sup_pkg::ADDR_POLICY, 16'h0000);
    rchk("count", comm_sup_pkg::ADDR_COUNT, 16'h0007);
    wr(comm_sup_pkg::ADDR_WAIT, 16'($urandom_range(9998, 1)));
    wr(comm_sup_pkg::ADDR_COUNT, 16'h0000);
    rchk("count", comm_sup_pkg::ADDR_COUNT, 16'h0000);
    for (int i = 0; i < 60 && nv_save !== 1'b1; i++) @(posedge ref_clk);
    bchk("save", 1'b1, nv_save);
    chk("saved", 16'h0000, nv_save_data);
    line_cut <= 1'b1;
    run(30);
    bchk("offline", 1'b0, coast_req | fault_output_signal);
    for (int p = 0; p < 4; p++) begin
      setup(p, 1'b1);
      line_cut <= 1'b1;
      run(4);
      line_cut <= 1'b0;
      run(12);
      bchk("glitch", 1'b0, fault_output_signal);
      rchk("count", comm_sup_pkg::ADDR_COUNT, 16'h0008);
      line_cut <= 1'b1;
      run(30);
      bchk("comm", 1'b1, comm_stop);
      bchk("coast", p == 0, coast_req);
      bchk("ind", alarm_for(p), line_fault_indication);
      rchk("status", comm_sup_pkg::ADDR_STATUS, status_exp(p));
      bchk("alarm", alarm_for(p), v[comm_sup_pkg::ST_ALARM]);
      rchk("hist", comm_sup_pkg::ADDR_HIST,
           {p < 2 ? 8'hA1 : 8'h00, 8'hA1});
      chk("hdisp", 16'h00A1, {8'h00, history_disp});
      line_cut <= 1'b0;
      run(20);
      bchk("restart", p == 2, seen);
      bchk("run", p > 1, cmd_out.run);
      if (p > 1) chk("cmd", cmd_set.speed, cmd_out.speed);
      if (p == 2) chk("restart cmd", cmd_set.speed, rs_speed);
      bchk("held", alarm_for(p), fault_output_signal);
      rchk("hist", comm_sup_pkg::ADDR_HIST,
           p < 2 ? 16'hA1A1 : 16'h0000);
      setup(p, 1'b1);
      opt_fault_pin <= 1'b1;
      run(30);
      opt_fault_pin <= 1'b0;
      bchk("ocoast", p == 0 || p == 3, coast_req);
      chk("ocode", 16'h00F1, {8'h00, alarm_code});
      bchk("oind", 1'b1, opt_fault_indication);
      run(10);
      bchk("oheld", 1'b1, fault_output_signal);
    end
    setup(2, 1'b1);
    line_cut <= 1'b1;
    for (int i = 0; i < 30 && decel_req !== 1'b1; i++) @(posedge ref_clk);
    line_cut <= 1'b0;
    run(7);
    bchk("resume", 1'b1, seen & ~stopped);
    setup(0, 1'b1);
    wr(comm_sup_pkg::ADDR_WAIT, 16'h0000);
    line_cut <= 1'b1;
    run(3);
    line_cut <= 1'b0;
    run(10);
    bchk("zero wait", 1'b1, fault_output_signal);
    end_sim();
  end
endmodule // comm_error_supervisor_test
bind comm_error_supervisor comm_sup_checker #(.SAVE_CYC(SAVE_CYC)) chk_inst (
  .ref_clk, .nrst, .req, .rdata, .net_mode, .coast_req, .restart_req,
  .comm_stop, .fault_output_signal, .line_fault_indication,
  .opt_fault_indication, .alarm_code, .nv_save);
`default_nettype wire
